// *** logic/opl_loop_config.v ***
// Configuration register bank for the optical power loops of channels 1 and 0.
// Assumes the serial host interface hands over single-byte register accesses
// on clk, and that the loop engines read the decoded outputs on the same clock.
// Reset is asynchronous and active high; every output reads zero while it is held.
`timescale 1ns/100ps
`default_nettype none
`include "opl_loop_config_regs.vh"

// How it works
// - Coarse step code 00..11 gives a first search step of 1, 8, 16, 32 LSBs.
// - Start select: 00 and 11 give zero, 01 previous current, 10 programmed code.
// - Initial phase code 00..11 gives 0, 63, 127 or 255 clock counts.
// - Decimation code gives factor two to the power of the code, 1 to 128.
// - Divider enable code 00..11 gives 0, 63, 127 or 255 clock counts.
module opl_loop_config
(
	// Clock and reset
	input wire clk,
	input wire rst,
	// Register access from the host interface
	input wire reg_wr_en,
	input wire reg_rd_en,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wr_data,
	output reg [7:0] reg_rd_data_ff,
	// Current codes from the loop engines and output registers
	input wire [9:0] channel_one_current,
	input wire [9:0] channel_one_prog_current,
	input wire [9:0] channel_zero_current,
	input wire [9:0] channel_zero_prog_current,
	// Loop 1 decoded configuration
	output wire [5:0] loop1_coarse_step,
	output wire [5:0] loop1_mid_step,
	output wire [4:0] loop1_clock_divide,
	output wire [9:0] loop1_start_current,
	output reg [7:0] loop1_decimation_ff,
	output reg loop1_gate_by_line_input_ff,
	output reg [1:0] loop1_start_delay_ff,
	output reg loop1_hold_ff,
	// Loop 0 decoded configuration
	output wire [5:0] loop0_coarse_step,
	output wire [5:0] loop0_mid_step,
	output wire [4:0] loop0_clock_divide,
	output wire [9:0] loop0_start_current,
	output reg [7:0] loop0_initial_phase_ff,
	output reg [7:0] loop0_middle_phase_ff,
	output reg [7:0] loop0_minimum_step_ff,
	output reg [7:0] loop0_divider_enable_ff
);

reg [7:0] loop1_step_config_ff;
reg [7:0] loop1_filter_config_ff;
reg [7:0] loop0_timing_config_ff;
reg [7:0] loop0_step_config_ff;
reg [7:0] nxt_rd_data;
reg [7:0] nxt_decimation;
reg [7:0] nxt_initial_phase;
reg [7:0] nxt_middle_phase;
reg [7:0] nxt_minimum_step;
reg [7:0] nxt_divider_enable;
wire [2:0] filter_decimation;
wire [1:0] initial_phase_count;
wire [1:0] middle_phase_count;
wire [1:0] minimum_step_count;
wire [1:0] divider_enable_count;
wire gate_by_line_input;
wire [1:0] loop_start_delay;
wire loop_hold;

////////////////////////////////////////////////////////////////////////////////
// Register storage.

// The reserved bit of the filter byte is never stored, so it always reads zero.
// Addresses outside the bank are ignored, so neighbouring banks can share the
// same write strobe without a separate select.
always @(posedge clk or posedge rst)
begin
	if (rst)
	begin
		loop1_step_config_ff <= `OPL_RESET_BYTE;
		loop1_filter_config_ff <= `OPL_RESET_BYTE;
		loop0_timing_config_ff <= `OPL_RESET_BYTE;
		loop0_step_config_ff <= `OPL_RESET_BYTE;
	end
	else if (reg_wr_en)
	begin
		case (reg_addr)
			`OPL_ADDR_LOOP1_STEP: loop1_step_config_ff <= reg_wr_data;
			`OPL_ADDR_LOOP1_FILTER: loop1_filter_config_ff <= reg_wr_data & `OPL_FILT_WRITE_MASK;
			`OPL_ADDR_LOOP0_TIMING: loop0_timing_config_ff <= reg_wr_data;
			`OPL_ADDR_LOOP0_STEP: loop0_step_config_ff <= reg_wr_data;
			default: loop1_step_config_ff <= loop1_step_config_ff;
		endcase
	end
end

// Read data is captured one cycle after the strobe and held until the next read.
// A read and a write on one edge return the old byte, because the mux looks at
// the stored value before that edge's write lands.
always @*
begin
	case (reg_addr)
		`OPL_ADDR_LOOP1_STEP: nxt_rd_data = loop1_step_config_ff;
		`OPL_ADDR_LOOP1_FILTER: nxt_rd_data = loop1_filter_config_ff;
		`OPL_ADDR_LOOP0_TIMING: nxt_rd_data = loop0_timing_config_ff;
		`OPL_ADDR_LOOP0_STEP: nxt_rd_data = loop0_step_config_ff;
		default: nxt_rd_data = `OPL_RESET_BYTE;
	endcase
end

always @(posedge clk or posedge rst)
begin
	if (rst)
		reg_rd_data_ff <= `OPL_RESET_BYTE;
	else if (reg_rd_en)
		reg_rd_data_ff <= nxt_rd_data;
end

////////////////////////////////////////////////////////////////////////////////
// Step configuration decode, one instance per loop.
// The start current follows the selected input with one cycle of delay at all
// times, so a loop engine must take it at its own start event.

opl_step_decode u_loop1_step
(
	.clk(clk),
	.rst(rst),
	.step_cfg(loop1_step_config_ff),
	.prev_current(channel_one_current),
	.prog_current(channel_one_prog_current),
	.coarse_step_ff(loop1_coarse_step),
	.mid_step_ff(loop1_mid_step),
	.clock_divide_ff(loop1_clock_divide),
	.start_current_ff(loop1_start_current)
);

opl_step_decode u_loop0_step
(
	.clk(clk),
	.rst(rst),
	.step_cfg(loop0_step_config_ff),
	.prev_current(channel_zero_current),
	.prog_current(channel_zero_prog_current),
	.coarse_step_ff(loop0_coarse_step),
	.mid_step_ff(loop0_mid_step),
	.clock_divide_ff(loop0_clock_divide),
	.start_current_ff(loop0_start_current)
);

////////////////////////////////////////////////////////////////////////////////
// Filter and timing decode.
// Only loop 1 has a filter byte and only loop 0 a timing byte in this bank;
// their counterparts sit beside the other channel's registers.

assign filter_decimation = loop1_filter_config_ff[`OPL_FILT_DEC_HI:`OPL_FILT_DEC_LO];
assign initial_phase_count = loop0_timing_config_ff[`OPL_TIM_INIT_HI:`OPL_TIM_INIT_LO];
assign middle_phase_count = loop0_timing_config_ff[`OPL_TIM_MID_HI:`OPL_TIM_MID_LO];
assign minimum_step_count = loop0_timing_config_ff[`OPL_TIM_MIN_HI:`OPL_TIM_MIN_LO];
assign divider_enable_count = loop0_timing_config_ff[`OPL_TIM_DIV_HI:`OPL_TIM_DIV_LO];

// Loop 1 filter flags pass through as plain levels.
assign gate_by_line_input = loop1_filter_config_ff[`OPL_FILT_LINE_BIT];
assign loop_start_delay = loop1_filter_config_ff[`OPL_FILT_WAIT_HI:`OPL_FILT_WAIT_LO];
assign loop_hold = loop1_filter_config_ff[`OPL_FILT_HOLD_BIT];

always @*
begin
	nxt_decimation = `OPL_DEC_ONE << filter_decimation;
	case (initial_phase_count)
		`OPL_CODE_0: nxt_initial_phase = `OPL_LONG_0;
		`OPL_CODE_1: nxt_initial_phase = `OPL_LONG_1;
		`OPL_CODE_2: nxt_initial_phase = `OPL_LONG_2;
		default: nxt_initial_phase = `OPL_LONG_3;
	endcase
	// Middle and minimum phase counts use the short table, one step below the long one.
	case (middle_phase_count)
		`OPL_CODE_0: nxt_middle_phase = `OPL_SHORT_0;
		`OPL_CODE_1: nxt_middle_phase = `OPL_SHORT_1;
		`OPL_CODE_2: nxt_middle_phase = `OPL_SHORT_2;
		default: nxt_middle_phase = `OPL_SHORT_3;
	endcase
	case (minimum_step_count)
		`OPL_CODE_0: nxt_minimum_step = `OPL_SHORT_0;
		`OPL_CODE_1: nxt_minimum_step = `OPL_SHORT_1;
		`OPL_CODE_2: nxt_minimum_step = `OPL_SHORT_2;
		default: nxt_minimum_step = `OPL_SHORT_3;
	endcase
	case (divider_enable_count)
		`OPL_CODE_0: nxt_divider_enable = `OPL_LONG_0;
		`OPL_CODE_1: nxt_divider_enable = `OPL_LONG_1;
		`OPL_CODE_2: nxt_divider_enable = `OPL_LONG_2;
		default: nxt_divider_enable = `OPL_LONG_3;
	endcase
end

// Decoded values are registered so the loop engines see glitch-free settings,
// at the cost of one cycle between a write and its effect.
always @(posedge clk or posedge rst)
begin
	if (rst)
	begin
		loop1_decimation_ff <= `OPL_RESET_DEC;
		loop1_gate_by_line_input_ff <= `OPL_RESET_BIT;
		loop1_start_delay_ff <= `OPL_RESET_WAIT;
		loop1_hold_ff <= `OPL_RESET_BIT;
		loop0_initial_phase_ff <= `OPL_RESET_COUNT;
		loop0_middle_phase_ff <= `OPL_RESET_COUNT;
		loop0_minimum_step_ff <= `OPL_RESET_COUNT;
		loop0_divider_enable_ff <= `OPL_RESET_COUNT;
	end
	else
	begin
		loop1_decimation_ff <= nxt_decimation;
		loop1_gate_by_line_input_ff <= gate_by_line_input;
		loop1_start_delay_ff <= loop_start_delay;
		loop1_hold_ff <= loop_hold;
		loop0_initial_phase_ff <= nxt_initial_phase;
		loop0_middle_phase_ff <= nxt_middle_phase;
		loop0_minimum_step_ff <= nxt_minimum_step;
		loop0_divider_enable_ff <= nxt_divider_enable;
	end
end

endmodule // opl_loop_config

`default_nettype wire

// *** logic/opl_loop_config_regs.vh ***
// Register map, field positions, reset values and decode constants of the
// optical power loop configuration bank. Included by the design files.
`ifndef OPL_LOOP_CONFIG_REGS_VH
`define OPL_LOOP_CONFIG_REGS_VH

// Register byte addresses.
`define OPL_ADDR_LOOP1_STEP 8'h45
`define OPL_ADDR_LOOP1_FILTER 8'h46
`define OPL_ADDR_LOOP0_TIMING 8'h47
`define OPL_ADDR_LOOP0_STEP 8'h48

// Reset values.
`define OPL_RESET_BYTE 8'h00
`define OPL_RESET_CURRENT 10'h000
`define OPL_RESET_COUNT 8'h00
`define OPL_RESET_STEP 6'h00
`define OPL_RESET_DIV 5'h00
`define OPL_RESET_DEC 8'h00
`define OPL_RESET_BIT 1'b0
`define OPL_RESET_WAIT 2'h0

// Step configuration fields.
`define OPL_STEP_COARSE_HI 7
`define OPL_STEP_COARSE_LO 6
`define OPL_STEP_MID_HI 5
`define OPL_STEP_MID_LO 4
`define OPL_STEP_START_HI 3
`define OPL_STEP_START_LO 2
`define OPL_STEP_CKDIV_HI 1
`define OPL_STEP_CKDIV_LO 0

// Filter configuration fields; bit 4 is reserved and reads zero.
`define OPL_FILT_DEC_HI 7
`define OPL_FILT_DEC_LO 5
`define OPL_FILT_LINE_BIT 3
`define OPL_FILT_WAIT_HI 2
`define OPL_FILT_WAIT_LO 1
`define OPL_FILT_HOLD_BIT 0
`define OPL_FILT_WRITE_MASK 8'hEF

// Timing configuration fields.
`define OPL_TIM_INIT_HI 7
`define OPL_TIM_INIT_LO 6
`define OPL_TIM_MID_HI 5
`define OPL_TIM_MID_LO 4
`define OPL_TIM_MIN_HI 3
`define OPL_TIM_MIN_LO 2
`define OPL_TIM_DIV_HI 1
`define OPL_TIM_DIV_LO 0

// Two-bit selector codes.
`define OPL_CODE_0 2'h0
`define OPL_CODE_1 2'h1
`define OPL_CODE_2 2'h2
`define OPL_CODE_3 2'h3

// Coarse step sizes in output LSBs.
`define OPL_COARSE_0 6'h01
`define OPL_COARSE_1 6'h08
`define OPL_COARSE_2 6'h10
`define OPL_COARSE_3 6'h20

// Loop clock divide ratios.
`define OPL_CKDIV_0 5'h01
`define OPL_CKDIV_1 5'h04
`define OPL_CKDIV_2 5'h08
`define OPL_CKDIV_3 5'h10

// Long phase counts: initial phase and divider enable.
`define OPL_LONG_0 8'h00
`define OPL_LONG_1 8'h3F
`define OPL_LONG_2 8'h7F
`define OPL_LONG_3 8'hFF

// Short phase counts: middle phase and minimum step.
`define OPL_SHORT_0 8'h00
`define OPL_SHORT_1 8'h1F
`define OPL_SHORT_2 8'h3F
`define OPL_SHORT_3 8'h7F

// Decimation: factor is one shifted left by the code.
`define OPL_DEC_ONE 8'h01

`endif

// *** logic/opl_step_decode.v ***
// Decodes one loop's step configuration byte into registered step sizes,
// divide ratio and start current. Inputs come from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
`include "opl_loop_config_regs.vh"

module opl_step_decode
(
	// Clock and reset
	input wire clk,
	input wire rst,
	// Configuration byte and current sources
	input wire [7:0] step_cfg,
	input wire [9:0] prev_current,
	input wire [9:0] prog_current,
	// Decoded values
	output reg [5:0] coarse_step_ff,
	output reg [5:0] mid_step_ff,
	output reg [4:0] clock_divide_ff,
	output reg [9:0] start_current_ff
);

wire [1:0] coarse_step_size;
wire [1:0] mid_step_fraction;
wire [1:0] start_current_select;
wire [1:0] loop_clock_divide;
reg [5:0] nxt_coarse_step;
reg [5:0] nxt_mid_step;
reg [4:0] nxt_clock_divide;
reg [9:0] nxt_start_current;

assign coarse_step_size = step_cfg[`OPL_STEP_COARSE_HI:`OPL_STEP_COARSE_LO];
assign mid_step_fraction = step_cfg[`OPL_STEP_MID_HI:`OPL_STEP_MID_LO];
assign start_current_select = step_cfg[`OPL_STEP_START_HI:`OPL_STEP_START_LO];
assign loop_clock_divide = step_cfg[`OPL_STEP_CKDIV_HI:`OPL_STEP_CKDIV_LO];

////////////////////////////////////////////////////////////////////////////////

always @*
begin
	case (coarse_step_size)
		`OPL_CODE_0: nxt_coarse_step = `OPL_COARSE_0;
		`OPL_CODE_1: nxt_coarse_step = `OPL_COARSE_1;
		`OPL_CODE_2: nxt_coarse_step = `OPL_COARSE_2;
		default: nxt_coarse_step = `OPL_COARSE_3;
	endcase
	// Reserved fractions give a zero middle step so the loop cannot run away.
	case (mid_step_fraction)
		`OPL_CODE_0: nxt_mid_step = {1'b0, nxt_coarse_step[5:1]};
		`OPL_CODE_1: nxt_mid_step = {2'b00, nxt_coarse_step[5:2]};
		default: nxt_mid_step = `OPL_RESET_STEP;
	endcase
	case (loop_clock_divide)
		`OPL_CODE_0: nxt_clock_divide = `OPL_CKDIV_0;
		`OPL_CODE_1: nxt_clock_divide = `OPL_CKDIV_1;
		`OPL_CODE_2: nxt_clock_divide = `OPL_CKDIV_2;
		default: nxt_clock_divide = `OPL_CKDIV_3;
	endcase
	case (start_current_select)
		`OPL_CODE_1: nxt_start_current = prev_current;
		`OPL_CODE_2: nxt_start_current = prog_current;
		default: nxt_start_current = `OPL_RESET_CURRENT;
	endcase
end

always @(posedge clk or posedge rst)
begin
	if (rst)
	begin
		coarse_step_ff <= `OPL_RESET_STEP;
		mid_step_ff <= `OPL_RESET_STEP;
		clock_divide_ff <= `OPL_RESET_DIV;
		start_current_ff <= `OPL_RESET_CURRENT;
	end
	else
	begin
		coarse_step_ff <= nxt_coarse_step;
		mid_step_ff <= nxt_mid_step;
		clock_divide_ff <= nxt_clock_divide;
		start_current_ff <= nxt_start_current;
	end
end

endmodule // opl_step_decode

`default_nettype wire

// *** verification/opl_loop_config_monitor.sv ***
// Concurrent checks on the loop configuration bank, seen from its ports.
// Assumes one clock, active-high asynchronous reset and the byte register port.
`timescale 1ns/100ps
`default_nettype none

module opl_loop_config_monitor
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Register port
	input wire logic reg_wr_en,
	input wire logic reg_rd_en,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wr_data,
	input wire logic [7:0] reg_rd_data_ff,
	// Current sources and decoded outputs
	input wire logic [9:0] channel_one_current,
	input wire logic [9:0] channel_zero_prog_current,
	input wire logic [5:0] loop1_coarse_step,
	input wire logic [9:0] loop1_start_current,
	input wire logic [7:0] loop1_decimation_ff,
	input wire logic [9:0] loop0_start_current,
	input wire logic [7:0] loop0_initial_phase_ff,
	input wire logic [7:0] loop0_divider_enable_ff
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	wire w45 = reg_wr_en && reg_addr == 8'h45;
	wire w46 = reg_wr_en && reg_addr == 8'h46;
	wire w47 = reg_wr_en && reg_addr == 8'h47;
	wire w48 = reg_wr_en && reg_addr == 8'h48;

	// Long counts are one short of a power of two, so a shift cannot give them.
	function automatic logic [7:0] long_cnt(input logic [1:0] c);
		long_cnt = c[1] ? (c[0] ? 8'hFF : 8'h7F) : (c[0] ? 8'h3F : 8'h00);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Decodes land one edge after the write edge and are sampled on the next edge.
	chk_coarse_step: assert property (w45 |-> ##2 loop1_coarse_step ==
		(($past(reg_wr_data[7:6], 2) == 2'h0) ? 6'h01 : 6'h04 << $past(reg_wr_data[7:6], 2)))
		else $error("coarse step differs from written code");
	chk_start_prev: assert property (w45 && reg_wr_data[3:2] == 2'h1 |->
		##2 loop1_start_current == $past(channel_one_current))
		else $error("start current does not follow previous current");
	chk_start_prog: assert property (w48 && reg_wr_data[3:2] == 2'h2 |->
		##2 loop0_start_current == $past(channel_zero_prog_current))
		else $error("start current does not follow programmed code");
	chk_init_phase: assert property (w47 |-> ##2 loop0_initial_phase_ff ==
		long_cnt($past(reg_wr_data[7:6], 2)))
		else $error("initial phase count wrong");
	chk_decimation: assert property (w46 |-> ##2 loop1_decimation_ff ==
		8'h01 << $past(reg_wr_data[7:5], 2))
		else $error("decimation factor wrong");
	chk_div_enable: assert property (w47 |-> ##2 loop0_divider_enable_ff ==
		long_cnt($past(reg_wr_data[1:0], 2)))
		else $error("divider enable count wrong");
	chk_read_back: assert property (w48 ##1 (reg_rd_en && !reg_wr_en && reg_addr == 8'h48) |->
		##1 reg_rd_data_ff == $past(reg_wr_data, 2))
		else $error("read back differs from written byte");
	chk_unmapped_read: assert property (reg_rd_en && (reg_addr < 8'h45 || reg_addr > 8'h48) |->
		##1 reg_rd_data_ff == 8'h00)
		else $error("unmapped read not zero");
endmodule // opl_loop_config_monitor

bind opl_loop_config opl_loop_config_monitor u_monitor (.clk, .rst, .reg_wr_en, .reg_rd_en,
	.reg_addr, .reg_wr_data, .reg_rd_data_ff, .channel_one_current, .channel_zero_prog_current,
	.loop1_coarse_step, .loop1_start_current, .loop1_decimation_ff, .loop0_start_current,
	.loop0_initial_phase_ff, .loop0_divider_enable_ff);

`default_nettype wire

// *** verification/opl_loop_config_tb.sv ***
// Self-checking bench for the loop configuration bank: byte accesses and decodes.
// Assumes a 10 MHz clock; inputs change on the falling edge only.
`timescale 1ns/100ps
`default_nettype none

module tb;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic wr = 1'b0;
	logic rd_en = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdat = 8'h00;
	logic [9:0] ch1_cur = 10'h0F3;
	logic [9:0] ch1_prog = 10'h30C;
	logic [9:0] ch0_cur = 10'h155;
	logic [9:0] ch0_prog = 10'h2AA;
	logic [3:0] fl = 4'h0;
	wire [7:0] rdat, l1_dec, l0_init, l0_den, l0_mid_ph, l0_min;
	wire [5:0] l1_coarse, l1_mid, l0_coarse, l0_mid;
	wire [4:0] l1_div, l0_div;
	wire [9:0] l1_start, l0_start;
	wire l1_gate, l1_hold;
	wire [1:0] l1_wait;
	int n_errors = 0;
	int n_compared = 0;
	logic [9:0] c_tab [4] = '{10'h001, 10'h008, 10'h010, 10'h020};
	logic [9:0] l_tab [4] = '{10'h000, 10'h03F, 10'h07F, 10'h0FF};
	logic [9:0] d_tab [4] = '{10'h001, 10'h004, 10'h008, 10'h010};
	logic [9:0] s_tab [4] = '{10'h000, 10'h01F, 10'h03F, 10'h07F};

	always #50 clk = ~clk;

	opl_loop_config dut (.clk(clk), .rst(rst), .reg_wr_en(wr), .reg_rd_en(rd_en), .reg_addr(addr),
		.reg_wr_data(wdat), .reg_rd_data_ff(rdat), .channel_one_current(ch1_cur),
		.channel_one_prog_current(ch1_prog), .channel_zero_current(ch0_cur),
		.channel_zero_prog_current(ch0_prog), .loop1_coarse_step(l1_coarse), .loop1_mid_step(l1_mid),
		.loop1_clock_divide(l1_div), .loop1_start_current(l1_start), .loop1_decimation_ff(l1_dec),
		.loop1_gate_by_line_input_ff(l1_gate), .loop1_start_delay_ff(l1_wait), .loop1_hold_ff(l1_hold),
		.loop0_coarse_step(l0_coarse), .loop0_mid_step(l0_mid), .loop0_clock_divide(l0_div),
		.loop0_start_current(l0_start), .loop0_initial_phase_ff(l0_init),
		.loop0_middle_phase_ff(l0_mid_ph), .loop0_minimum_step_ff(l0_min), .loop0_divider_enable_ff(l0_den));

	////////////////////////////////////////////////////////////////////////////////
	task automatic final_report;
		if (n_errors == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic cmp(input logic [9:0] got, input logic [9:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One access per cycle; both strobes, address and data are set together, so one strobe can fall as the other rises.
	task automatic acc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
		wr = w;
		rd_en = r;
		addr = a;
		wdat = d;
		@(negedge clk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		acc(1'b0, 1'b1, a, 8'h00);
		cmp(10'(rdat), 10'(e));
	endtask

	task automatic check_reset;
		for (int a = 8'h45; a <= 8'h48; a++)
			rd(8'(a), 8'h00);
		cmp(10'(l1_coarse), 10'h001);
		cmp(10'(l1_dec), 10'h001);
		cmp(10'(l0_init), 10'h000);
		cmp(10'(l0_den), 10'h000);
		cmp(l0_start, 10'h000);
		cmp(10'(l0_coarse), 10'h001);
		cmp(10'({l1_gate, l1_wait, l1_hold}), 10'h000);
		cmp(10'(l0_mid_ph), 10'h000);
		cmp(10'(l0_min), 10'h000);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (20) @(negedge clk);
		rst = 1'b0;
		acc(1'b0, 1'b0, 8'h00, 8'h00);
		check_reset();
		for (int c = 0; c < 4; c++)
		begin
			ch1_cur = ~ch1_cur;
			ch1_prog = ~ch1_prog;
			ch0_cur = ~ch0_cur;
			ch0_prog = ~ch0_prog;
			acc(1'b1, 1'b0, 8'h45, {2'(c), 2'h0, 2'(c), 2'(c)});
			acc(1'b1, 1'b0, 8'h47, {4{2'(c)}});
			acc(1'b1, 1'b0, 8'h48, {4{2'(c)}});
			rd(8'h48, {4{2'(c)}});
			rd(8'h47, {4{2'(c)}});
			rd(8'h45, {2'(c), 2'h0, 2'(c), 2'(c)});
			cmp(10'(l1_coarse), c_tab[c]);
			cmp(10'(l1_div), d_tab[c]);
			cmp(10'(l0_init), l_tab[c]);
			cmp(10'(l0_den), l_tab[c]);
			cmp(10'(l1_mid), c_tab[c] >> 1);
			cmp(10'(l0_coarse), c_tab[c]);
			cmp(10'(l0_mid), (c == 0) ? (c_tab[c] >> 1) : (c == 1) ? (c_tab[c] >> 2) : 10'h000);
			cmp(10'(l0_div), d_tab[c]);
			cmp(10'(l0_mid_ph), s_tab[c]);
			cmp(10'(l0_min), s_tab[c]);
			cmp(l1_start, (c == 1) ? ch1_cur : (c == 2) ? ch1_prog : 10'h000);
			cmp(l0_start, (c == 1) ? ch0_cur : (c == 2) ? ch0_prog : 10'h000);
		end
		// The reserved bit is written as one and must read back as zero.
		for (int k = 0; k < 8; k++)
		begin
			fl = 4'(k * 3);
			acc(1'b1, 1'b0, 8'h46, {3'(k), 1'b1, fl});
			rd(8'h46, {3'(k), 1'b0, fl});
			cmp(10'(l1_dec), 10'h001 << k);
			cmp(10'({l1_gate, l1_wait, l1_hold}), 10'(fl));
		end
		acc(1'b1, 1'b0, 8'h44, 8'hFF);
		acc(1'b1, 1'b0, 8'h49, 8'hFF);
		rd(8'h44, 8'h00);
		rd(8'h49, 8'h00);
		acc(1'b1, 1'b1, 8'h48, 8'h5A);
		cmp(10'(rdat), 10'h0FF);
		rd(8'h48, 8'h5A);
		acc(1'b0, 1'b0, 8'h00, 8'h00);
		rst = 1'b1;
		repeat (3) @(negedge clk);
		rst = 1'b0;
		acc(1'b0, 1'b0, 8'h00, 8'h00);
		check_reset();
		final_report();
	end

	initial
	begin
		repeat (5000) @(posedge clk);
		n_errors++;
		final_report();
	end
endmodule // tb

`default_nettype wire
